// >>> hw/spcs_pkg.sv
`default_nettype none
package spcs_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [2:0] IDX_RATE = 3'h0;
  localparam logic [2:0] IDX_MODE = 3'h1;
  localparam logic [2:0] IDX_IEN = 3'h2;
  localparam logic [2:0] IDX_FLAGS = 3'h3;
  localparam logic [2:0] IDX_DATA = 3'h4;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Bit positions
  localparam int RATE_EN = 0;
  localparam int RATE_SCK_PRESCALE_SEL = 1;
  localparam int RATE_DBL = 4;
  localparam int RATE_HOST = 5;
  localparam int RATE_DORD = 6;
  localparam int MODE_MODE = 0;
  localparam int MODE_SSD = 2;
  localparam int MODE_BUFFER_WAIT_RECEIVE = 6;
  localparam int MODE_BUFFER_MODE_ON = 7;
  localparam int IEN_IE = 0;
  localparam logic [7:0] IEN_MASK = 8'hF1;
  localparam int FLG_OVF = 0;
  localparam int FLG_SELECT_TRIG_FLAG = 4;
  localparam int FLG_DRE = 5;
  localparam int FLG_TXC = 6;
  localparam int FLG_RXC = 7;
  localparam int FLG_WCOL = 6;
  localparam int FLG_IF = 7;
  // Peripheral clock divisors per prescale code
  localparam logic [7:0] DIV_4 = 8'h04;
  localparam logic [7:0] DIV_16 = 8'h10;
  localparam logic [7:0] DIV_64 = 8'h40;
  localparam logic [7:0] DIV_128 = 8'h80;
  localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
  localparam logic [2:0] LAST_BIT = 3'h7;
endpackage
`default_nettype wire

// >>> hw/spcs_top.sv
// Notes on behaviour
// - Clock-double set in host mode halves the SCK period.
// - Host SCK is peripheral clock divided by 4, 16, 64 or 128.
// - Client mode ignores prescale and double; SCK comes from outside.
// - Unit runs only while the enable bit is one.
// - Buffer mode adds two receive bytes, one transmit byte, own flags.
// - Wait-for-receive clear: buffered byte enters shifter only after a transfer.
// - Wait-for-receive set: first write while enabled, select high, loads shifter.
// - Select-disable set keeps host mode despite select low.
// - Mode bits choose leading edge direction and sample or setup.
// - SCK idles low for rising leading edge, high for falling.
// - Buffer-mode enables work and read back only in buffer mode.
// - Normal mode: enable bit zero gates transfer flag onto interrupt.
// - Normal transfer flag sets after a full byte shifts.
// - Normal transfer flag also sets when host sees select driven low.
// - Transfer flag clears on vector acknowledge, or flags read then data access.
// - Write collision sets when data written mid-byte.
// - Write collision clears by flags read then data access.
// - Receive-complete flag shows unread data in the receive buffer.
// - Writing one to receive-complete flag empties buffer and clears it.
// - Transfer-complete sets when shifter done and buffer empty; write one clears.
// - Flag register layout follows buffer mode setting.
// - Interrupt stays high while any enabled flag is set.
// - Select low in host mode without disable drops host and sets flag.
// - Data-empty flag shows empty transmit buffer; data write clears it.
// - Select-trigger flag sets on host select fault; write one clears.
//
// Local design decision: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module spcs_top #(
  parameter int ADDR_W = 8
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Interrupt
  input wire logic i_irq_ack,
  output logic o_irq,
  // Serial link
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_miso,
  input wire logic i_ss_n,
  input wire logic i_ss_is_input,
  output logic o_sck,
  output logic o_sck_oe,
  output logic o_mosi,
  output logic o_mosi_oe,
  output logic o_miso,
  output logic o_miso_oe
);
  if (ADDR_W < 5) $error("ADDR_W too small for register map");

  typedef struct packed {
    logic en, host, dbl, dord;
    logic [1:0] sck_prescale_sel;
    logic buffer_mode_on, buffer_wait_receive, select_line_disable;
    logic [1:0] mode;
    logic [7:0] ien;
    logic iflag, wcol, txc, select_trig_flag, ovf, arm_if, arm_wcol;
    logic [7:0] txb;
    logic txf, primed;
    logic [7:0] rxa, rxb;
    logic [1:0] rxn;
    logic [7:0] sr;
    logic busy;
    logic [4:0] edges;
    logic [2:0] bits;
    logic [6:0] div;
    logic sck, sck_q, dout;
    logic sck_oe, mosi_oe, miso_oe, irq, pready, pslverr;
    logic [7:0] prdata;
  } spcs_state_type;

  spcs_state_type s, n;

  function automatic logic [6:0] half_cycles(input logic [1:0] p, input logic d);
    logic [7:0] h;
    unique case (p)
      2'h0: h = spcs_pkg::DIV_4 >> 1;
      2'h1: h = spcs_pkg::DIV_16 >> 1;
      2'h2: h = spcs_pkg::DIV_64 >> 1;
      2'h3: h = spcs_pkg::DIV_128 >> 1;
    endcase
    if (d)
      h = h >> 1;
    return h[6:0] - 7'h01;
  endfunction

  function automatic logic out_bit(input logic [7:0] r, input logic lsb);
    return lsb ? r[0] : r[7];
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] r, input logic b, input logic lsb);
    return lsb ? {b, r[7:1]} : {r[6:0], b};
  endfunction

  logic acc, wr, rd, hit, act, done, fault, lead, smp;
  logic [2:0] idx;
  logic [7:0] wd, rmux, got;

  always_comb
  begin
    n = s;
    done = 1'b0;
    lead = 1'b0;
    smp = 1'b0;
    // Received byte as it stands at the last edge, before any buffered reload
    got = s.sr;
    idx = i_paddr[4:2];
    wd = i_pwdata[7:0];
    acc = i_psel & i_penable & s.pready;
    wr = acc & i_pwrite;
    rd = acc & ~i_pwrite;
    hit = (i_paddr[1:0] == 2'h0) && (idx <= spcs_pkg::IDX_DATA)
      && ((i_paddr >> 5) == '0);
    act = s.busy | (s.bits != 3'h0);
    fault = s.en & s.host & i_ss_is_input & ~i_ss_n & ~s.select_line_disable;
    n.sck_q = i_sck;

    // Shift engine
    if (!s.en)
    begin
      n.busy = 1'b0;
      n.bits = 3'h0;
      n.sck = s.mode[1];
    end
    else if (s.host)
    begin
      if (s.busy)
      begin
        if (s.div != 7'h00)
          n.div = s.div - 7'h01;
        else
        begin
          n.div = half_cycles(s.sck_prescale_sel, s.dbl);
          n.sck = ~s.sck;
          lead = ~s.edges[0];
          smp = lead ^ s.mode[0];
          if (smp)
            n.sr = shift_in(s.sr, i_miso, s.dord);
          else
            n.dout = out_bit(s.sr, s.dord);
          n.edges = s.edges + 5'h01;
          if (n.edges == spcs_pkg::EDGES_PER_BYTE)
          begin
            n.busy = 1'b0;
            done = 1'b1;
            got = n.sr;
          end
        end
      end
      else
      begin
        n.sck = s.mode[1];
        if (s.buffer_mode_on && s.txf)
        begin
          n.sr = s.txb;
          n.dout = out_bit(s.txb, s.dord);
          n.txf = 1'b0;
          n.busy = 1'b1;
          n.edges = 5'h00;
          n.div = half_cycles(s.sck_prescale_sel, s.dbl);
        end
      end
    end
    else if (i_ss_n)
    begin
      // Deselect aborts a partial byte
      n.bits = 3'h0;
      n.dout = out_bit(s.sr, s.dord);
    end
    else if (i_sck != s.sck_q)
    begin
      lead = i_sck != s.mode[1];
      smp = lead ^ s.mode[0];
      if (smp)
      begin
        n.sr = shift_in(s.sr, i_mosi, s.dord);
        n.bits = s.bits + 3'h1;
        if (s.bits == spcs_pkg::LAST_BIT)
        begin
          done = 1'b1;
          got = n.sr;
          n.primed = 1'b0;
          if (s.buffer_mode_on && s.txf)
          begin
            n.sr = s.txb;
            n.txf = 1'b0;
          end
        end
      end
      else
        n.dout = out_bit(s.sr, s.dord);
    end

    // Register writes and access side effects
    if (wr && hit)
    begin
      unique case (idx)
        spcs_pkg::IDX_RATE:
        begin
          n.en = wd[spcs_pkg::RATE_EN];
          n.sck_prescale_sel = wd[spcs_pkg::RATE_SCK_PRESCALE_SEL +: 2];
          n.dbl = wd[spcs_pkg::RATE_DBL];
          n.host = wd[spcs_pkg::RATE_HOST];
          n.dord = wd[spcs_pkg::RATE_DORD];
        end
        spcs_pkg::IDX_MODE:
        begin
          n.mode = wd[spcs_pkg::MODE_MODE +: 2];
          n.select_line_disable = wd[spcs_pkg::MODE_SSD];
          n.buffer_wait_receive = wd[spcs_pkg::MODE_BUFFER_WAIT_RECEIVE];
          n.buffer_mode_on = wd[spcs_pkg::MODE_BUFFER_MODE_ON];
        end
        spcs_pkg::IDX_IEN: n.ien = wd & spcs_pkg::IEN_MASK;
        spcs_pkg::IDX_FLAGS:
          if (s.buffer_mode_on)
          begin
            if (wd[spcs_pkg::FLG_RXC])
              n.rxn = 2'h0;
            if (wd[spcs_pkg::FLG_TXC])
              n.txc = 1'b0;
            if (wd[spcs_pkg::FLG_SELECT_TRIG_FLAG])
              n.select_trig_flag = 1'b0;
            if (wd[spcs_pkg::FLG_OVF])
              n.ovf = 1'b0;
          end
        default:
          if (!s.buffer_mode_on)
          begin
            if (act)
              n.wcol = 1'b1;
            else
            begin
              n.sr = wd;
              n.dout = out_bit(wd, s.dord);
              if (s.en && s.host)
              begin
                n.busy = 1'b1;
                n.edges = 5'h00;
                n.div = half_cycles(s.sck_prescale_sel, s.dbl);
              end
            end
          end
          else if (s.buffer_wait_receive && s.en && !s.host && i_ss_n && !act && !s.primed && !s.txf)
          begin
            n.sr = wd;
            n.dout = out_bit(wd, s.dord);
            n.primed = 1'b1;
          end
          else
          begin
            n.txb = wd;
            n.txf = 1'b1;
          end
      endcase
    end
    if (rd && hit && idx == spcs_pkg::IDX_FLAGS && !s.buffer_mode_on)
    begin
      n.arm_if = s.iflag;
      n.arm_wcol = s.wcol;
    end
    if (acc && hit && idx == spcs_pkg::IDX_DATA)
    begin
      if (!s.buffer_mode_on)
      begin
        if (s.arm_if)
          n.iflag = 1'b0;
        // A colliding write in the same access keeps the flag set
        if (s.arm_wcol && !(wr && act))
          n.wcol = 1'b0;
        n.arm_if = 1'b0;
        n.arm_wcol = 1'b0;
      end
      else if (rd)
      begin
        n.ovf = 1'b0;
        if (s.rxn != 2'h0)
        begin
          n.rxa = s.rxb;
          n.rxn = s.rxn - 2'h1;
        end
      end
    end
    if (i_irq_ack && !s.buffer_mode_on)
      n.iflag = 1'b0;

    // Hardware sets come last so they win over clears
    if (done)
    begin
      if (!s.buffer_mode_on)
      begin
        n.rxa = got;
        n.iflag = 1'b1;
      end
      else
      begin
        unique case (n.rxn)
          2'h0: n.rxa = got;
          2'h1: n.rxb = got;
          default: n.ovf = 1'b1;
        endcase
        if (n.rxn != 2'h2)
          n.rxn = n.rxn + 2'h1;
        if (!s.txf)
          n.txc = 1'b1;
      end
    end
    if (fault)
    begin
      n.host = 1'b0;
      n.busy = 1'b0;
      if (s.buffer_mode_on)
        n.select_trig_flag = 1'b1;
      else
        n.iflag = 1'b1;
    end

    // APB answer, one wait state
    n.pready = i_psel & i_penable & ~s.pready;
    n.pslverr = n.pready & ~hit;
    unique case (idx)
      spcs_pkg::IDX_RATE: rmux = {1'b0, s.dord, s.host, s.dbl, 1'b0, s.sck_prescale_sel, s.en};
      spcs_pkg::IDX_MODE: rmux = {s.buffer_mode_on, s.buffer_wait_receive, 3'h0, s.select_line_disable, s.mode};
      spcs_pkg::IDX_IEN: rmux = s.buffer_mode_on ? s.ien : {7'h00, s.ien[spcs_pkg::IEN_IE]};
      spcs_pkg::IDX_FLAGS: rmux = s.buffer_mode_on
        ? {s.rxn != 2'h0, s.txc, ~s.txf, s.select_trig_flag, 3'h0, s.ovf}
        : {s.iflag, s.wcol, 6'h00};
      spcs_pkg::IDX_DATA: rmux = s.rxa;
      default: rmux = spcs_pkg::RST_BYTE;
    endcase
    if (n.pready)
      n.prdata = hit ? rmux : spcs_pkg::RST_BYTE;

    // Pin enables and interrupt
    n.sck_oe = n.en & n.host;
    n.mosi_oe = n.en & n.host;
    n.miso_oe = n.en & ~n.host & ~i_ss_n;
    if (n.buffer_mode_on)
      n.irq = |(n.ien[7:4] & {n.rxn != 2'h0, n.txc, ~n.txf, n.select_trig_flag});
    else
      n.irq = n.ien[spcs_pkg::IEN_IE] & n.iflag;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      s <= '0;
    else if (i_ce)
      s <= n;
  end

  assign o_prdata = {24'h000000, s.prdata};
  assign o_pready = s.pready;
  assign o_pslverr = s.pslverr;
  assign o_irq = s.irq;
  assign o_sck = s.sck;
  assign o_sck_oe = s.sck_oe;
  assign o_mosi = s.dout;
  assign o_mosi_oe = s.mosi_oe;
  assign o_miso = s.dout;
  assign o_miso_oe = s.miso_oe;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn || !i_ce);

  a_rate_div4: assert property (
    $rose(s.sck) && s.busy && s.host && s.sck_prescale_sel == 2'h0 && !s.dbl |=> s.sck ##1 !s.sck)
    else $error("host SCK half period not two cycles");
  a_rate_double: assert property (
    $rose(s.sck) && s.busy && s.host && s.sck_prescale_sel == 2'h0 && s.dbl |=> !s.sck)
    else $error("doubled SCK half period not one cycle");
  a_sck_idle: assert property (
    s.host && s.en && !s.busy && $past(!s.busy) && $stable(s.mode) |-> s.sck == s.mode[1])
    else $error("SCK idle level wrong");
  a_enable_stops: assert property (
    !s.en && $past(!s.en) |-> !s.busy && s.bits == 3'h0)
    else $error("engine active while disabled");
  a_ss_fault: assert property (
    s.en && s.host && i_ss_is_input && !i_ss_n && !s.select_line_disable
    |=> !s.host && (s.buffer_mode_on ? s.select_trig_flag : s.iflag))
    else $error("select fault not handled");
  a_ssd_keeps: assert property (
    s.en && s.host && s.select_line_disable && !(i_psel && i_penable && i_pwrite) |=> s.host)
    else $error("host mode lost with select disabled");
  a_wcol_set: assert property (
    !s.buffer_mode_on && s.busy && s.pready && i_psel && i_penable && i_pwrite
    && i_paddr == ADDR_W'(4 * spcs_pkg::IDX_DATA) |=> s.wcol)
    else $error("write collision missed");
  a_irq_normal: assert property (
    !s.buffer_mode_on && s.ien[spcs_pkg::IEN_IE] && s.iflag |-> o_irq)
    else $error("normal interrupt not raised");
  a_ien_masked: assert property (
    o_pready && !i_pwrite && i_paddr == ADDR_W'(4 * spcs_pkg::IDX_IEN) && !s.buffer_mode_on
    |-> o_prdata[7:1] == 7'h00)
    else $error("buffer enables visible in normal mode");
endmodule
`default_nettype wire

// >>> tb/spcs_client_model.sv
`timescale 1ns/1ns
`default_nettype none
module spcs_client_model (
  // Clock and select
  input wire logic i_clk,
  input wire logic i_sel_n,
  input wire logic [1:0] i_mode,
  // Serial link
  input wire logic [7:0] i_tx,
  input wire logic i_sck,
  input wire logic i_mosi,
  output logic o_miso,
  output logic [7:0] o_rx
);
  logic last_sck = 1'b0;
  logic wander = 1'b0;
  logic [7:0] rx = 8'h00;
  int idx = 0;
  logic edge_seen;
  assign o_rx = rx;
  assign edge_seen = i_sck != last_sck;
  // Outside a byte the line wanders, so a stale bit never looks valid
  assign o_miso = (!i_sel_n && idx >= 0 && idx < 8) ? i_tx[7 - idx] : wander;
  always @(posedge i_clk)
  begin
    last_sck <= i_sck;
    wander <= ~wander;
    if (i_sel_n)
      idx <= i_mode[0] ? -1 : 0;
    else if (edge_seen && ((i_sck != i_mode[1]) ^ i_mode[0]))
      rx <= {rx[6:0], i_mosi};
    else if (edge_seen)
      idx <= idx + 1;
  end
endmodule
`default_nettype wire

// >>> tb/spcs_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module spcs_top_test;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic ack = 1'b0;
  logic ss_n = 1'b1;
  logic ss_in = 1'b0;
  logic sel_n = 1'b1;
  logic [1:0] pm_mode = 2'h0;
  logic [7:0] pm_tx = 8'h00;
  logic [7:0] pm_rx;
  logic [31:0] prdata;
  logic pready, pslverr, irq, sck, mosi, miso;
  logic hsck = 1'b0;
  logic hmosi = 1'b0;
  logic sck_oe, mosi_oe, dmiso, miso_oe;
  logic [7:0] q;
  logic [15:0] r;
  logic e;
  logic [31:0] seed = 32'h000080D4;
  int miscompares = 0;
  int samples_checked = 0;
  int edges, span;

  initial forever #2 i_clk = ~i_clk;

  spcs_top dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(1'b1), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_irq_ack(ack),
    .o_irq(irq), .i_sck(hsck), .i_mosi(hmosi), .i_miso(miso), .i_ss_n(ss_n),
    .i_ss_is_input(ss_in), .o_sck(sck), .o_sck_oe(sck_oe), .o_mosi(mosi),
    .o_mosi_oe(mosi_oe), .o_miso(dmiso), .o_miso_oe(miso_oe));
  spcs_client_model pm (.i_clk(i_clk), .i_sel_n(sel_n), .i_mode(pm_mode), .i_tx(pm_tx),
    .i_sck(sck), .i_mosi(mosi), .o_miso(miso), .o_rx(pm_rx));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic int half(input logic [1:0] p, input logic dbl);
    int d;
    d = p == 2'h0 ? 4 : p == 2'h1 ? 16 : p == 2'h2 ? 64 : 128;
    return dbl ? d / 4 : d / 2;
  endfunction

  task automatic finish_test;
    $display("Checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge i_clk);
    pen <= 1'b1;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      miscompares++;
    r = prdata[15:0];
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    apb(1'b0, a, 8'h00);
    chk(r, exp);
  endtask

  // Writes a byte, then counts SCK edges and the span from first to last
  task automatic xfer(input logic [7:0] d, input int lim);
    int c, first;
    logic last;
    sel_n <= 1'b0;
    apb(1'b1, 8'h10, d);
    edges = 0;
    span = 0;
    first = 0;
    c = 0;
    last = sck;
    repeat (lim)
    begin
      @(posedge i_clk);
      c++;
      if (sck !== last)
      begin
        if (edges == 0)
          first = c;
        edges++;
        span = c - first;
        last = sck;
      end
    end
    sel_n <= 1'b1;
  endtask

  // Plays an outside mode-0 host; slow edges give the client time to settle
  task automatic host_byte(input logic [7:0] d, output logic [7:0] got);
    for (int b = 7; b >= 0; b--)
    begin
      hmosi <= d[b];
      repeat (3) @(posedge i_clk);
      got[b] = dmiso;
      hsck <= 1'b1;
      repeat (3) @(posedge i_clk);
      hsck <= 1'b0;
    end
    repeat (3) @(posedge i_clk);
  endtask

  initial
  begin
    #100000;
    miscompares++;
    finish_test();
  end

  initial
  begin
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(8'h00, 16'h0000);
    rd(8'h04, 16'h0000);
    rd(8'h08, 16'h0000);
    rd(8'h0C, 16'h0000);
    apb(1'b0, 8'h14, 8'h00);
    chk({15'h0000, e}, 16'h0001);
    apb(1'b1, 8'h00, 8'h20);
    xfer(8'hA5, 200);
    chk(edges[15:0], 16'h0000);
    apb(1'b1, 8'h08, 8'h01);
    for (int k = 0; k < 8; k++)
    begin
      logic [1:0] m;
      logic [1:0] p;
      logic [7:0] d;
      int h;
      m = k[1:0];
      p = k[2:1];
      h = half(p, k[0]);
      seed = xs(seed);
      d = seed[15:8];
      pm_tx <= seed[7:0];
      pm_mode <= m;
      apb(1'b1, 8'h04, {6'h00, m});
      apb(1'b1, 8'h00, {3'h1, k[0], 1'b0, p, 1'b1});
      chk({15'h0000, sck}, {15'h0000, m[1]});
      xfer(d, 17 * h + 8);
      chk(edges[15:0], 16'h0010);
      chk(span[15:0], 16'(15 * h));
      repeat (4) @(posedge i_clk);
      // A one-cycle half period outruns the model, so data goes unchecked
      if (h > 1)
        chk({8'h00, pm_rx}, {8'h00, d});
      rd(8'h0C, 16'h0080);
      chk({15'h0000, irq}, 16'h0001);
      if (m == 2'h3)
      begin
        ack <= 1'b1;
        @(posedge i_clk);
        ack <= 1'b0;
      end
      else
      begin
        apb(1'b0, 8'h10, 8'h00);
        if (h > 1)
          chk(r, {8'h00, pm_tx});
      end
      rd(8'h0C, 16'h0000);
      chk({15'h0000, irq}, 16'h0000);
    end
    pm_mode <= 2'h0;
    apb(1'b1, 8'h04, 8'h00);
    apb(1'b1, 8'h00, 8'h21);
    apb(1'b1, 8'h10, 8'h3C);
    xfer(8'hC3, 60);
    repeat (4) @(posedge i_clk);
    rd(8'h0C, 16'h00C0);
    apb(1'b0, 8'h10, 8'h00);
    rd(8'h0C, 16'h0000);
    ss_in <= 1'b1;
    ss_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    rd(8'h00, 16'h0001);
    rd(8'h0C, 16'h0080);
    apb(1'b0, 8'h10, 8'h00);
    apb(1'b1, 8'h04, 8'h04);
    apb(1'b1, 8'h00, 8'h21);
    repeat (4) @(posedge i_clk);
    rd(8'h00, 16'h0021);
    ss_n <= 1'b1;
    apb(1'b1, 8'h08, 8'hF1);
    rd(8'h08, 16'h0001);
    apb(1'b1, 8'h04, 8'h80);
    rd(8'h08, 16'h00F1);
    rd(8'h0C, 16'h0020);
    chk({15'h0000, irq}, 16'h0001);
    xfer(8'h5A, 60);
    repeat (4) @(posedge i_clk);
    rd(8'h0C, 16'h00E0);
    apb(1'b1, 8'h0C, 8'hC0);
    rd(8'h0C, 16'h0020);
    apb(1'b0, 8'h10, 8'h00);
    chk(r, {8'h00, pm_tx});
    chk({8'h00, pm_rx}, 16'h005A);
    ss_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    rd(8'h0C, 16'h0030);
    ss_n <= 1'b1;
    apb(1'b1, 8'h0C, 8'h10);
    rd(8'h0C, 16'h0020);
    // Client mode with prescale and double set: the bench is the host
    apb(1'b1, 8'h00, 8'h17);
    apb(1'b1, 8'h04, 8'hC0);
    apb(1'b1, 8'h10, 8'h96);
    apb(1'b1, 8'h10, 8'h4E);
    rd(8'h0C, 16'h0000);
    ss_n <= 1'b0;
    host_byte(8'h3B, q);
    chk({8'h00, q}, 16'h0096);
    chk({13'h0000, sck_oe, mosi_oe, miso_oe}, 16'h0001);
    host_byte(8'hD2, q);
    chk({8'h00, q}, 16'h004E);
    ss_n <= 1'b1;
    rd(8'h10, 16'h003B);
    rd(8'h10, 16'h00D2);
    rd(8'h0C, 16'h0060);
    finish_test();
  end
endmodule
`default_nettype wire
